//--- include/idei_pkg.sv
package idei_pkg;
   // Register offsets
   localparam logic [5:0] ADDR_EN_WR = 6'h1d;
   localparam logic [5:0] ADDR_EN_SET = 6'h1e;
   localparam logic [5:0] ADDR_EN_CLR = 6'h1f;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   localparam logic [5:0] ADDR_LATCH = 6'h21;
   localparam logic [5:0] ADDR_VEND_WR = 6'h36;
   localparam logic [5:0] ADDR_VEND_SET = 6'h37;
   localparam logic [5:0] ADDR_VEND_CLR = 6'h38;
   // Field positions
   localparam int EN_RISE_BIT = 0;
   localparam int EN_FALL_BIT = 1;
   localparam int EN_CONV_BIT = 5;
   localparam logic [7:0] EN_WMASK = 8'h23;
   localparam int LATCH_ID_BIT = 0;
   localparam int LATCH_CONV_BIT = 3;
   localparam int VEND_DONE_BIT = 3;
   localparam int VEND_GO_BIT = 4;
   localparam int VEND_IEN_BIT = 6;
   // Reset values
   localparam logic [7:0] EN_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [2:0] CODE_RESET = 3'h0;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_US = 282;
   localparam int CONV_CYCLES_DEF = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 16;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } idei_reg_req_t;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_BUSY = 2'b01
   } idei_conv_state_t;
endpackage

//--- rtl/idei_sync.sv
`timescale 1ns/1ps
`default_nettype none
module idei_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Asynchronous level in, filtered level out
   input wire logic i_async,
   output logic o_level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_next;

   // Level changes only once the second and third stages agree
   always_comb begin
      level_next = o_level;
      if (s2_reg == s3_reg) begin
         level_next = s3_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         o_level <= level_next;
      end
   end
endmodule
`default_nettype wire

//--- rtl/idei_top.sv
`timescale 1ns/1ps
`default_nettype none
module idei_top
   import idei_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register access from the link
   input wire idei_reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // ID sense and resistor converter
   input wire logic i_id_open,
   input wire logic [2:0] i_resistor_code_meas,
   output logic o_resistor_conv_go,
   // Event to the RXCMD builder
   output logic o_alt_int
);
   localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);

   // Write, set and clear of one register sit at base, base+1 and base+2
   function automatic logic [7:0] apply_wr(input logic [7:0] cur, input logic [7:0] wd,
                                           input logic [7:0] mask, input logic [5:0] addr,
                                           input logic [5:0] base);
      logic [7:0] res;
      res = cur;
      if (addr == base) begin
         res = wd & mask;
      end else if (addr == base + 6'h01) begin
         res = cur | (wd & mask);
      end else if (addr == base + 6'h02) begin
         res = cur & ~(wd & mask);
      end
      return res;
   endfunction

   logic id_open_now;
   logic id_prev_reg, id_prev_next;
   logic [7:0] en_reg, en_next;
   logic [7:0] latch_reg, latch_next;
   logic [2:0] code_reg, code_next;
   logic done_reg, done_next;
   logic vend_ien_reg, vend_ien_next;
   logic go_reg, go_next;
   idei_conv_state_t state_reg, state_next;
   logic [CONV_CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] rdata_next;
   logic rvalid_next;
   logic alt_next;
   logic conv_end;
   logic conv_irq_en;
   logic id_rise, id_fall;
   logic [7:0] status_val, vend_val, vend_wr;

   // The ID comparator runs on no clock of ours, so its level is filtered first
   idei_sync u_id_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_id_open),
      .o_level(id_open_now)
   );

   assign id_rise = id_open_now & ~id_prev_reg;
   assign id_fall = ~id_open_now & id_prev_reg;
   assign conv_irq_en = en_reg[EN_CONV_BIT] | vend_ien_reg;
   // Completion also needs start still set, so a start cleared on the last count aborts cleanly
   assign conv_end = (state_reg == CONV_BUSY) && (cnt_reg == CONV_LAST) && go_reg;

   // Status is rebuilt every cycle, so the float bit is live and never held
   assign status_val = {1'b0, done_reg, code_reg, 2'b00, id_open_now};
   assign vend_val = {1'b0, vend_ien_reg, 1'b0, go_reg, done_reg, code_reg};
   // Only start and interrupt enable are writable in the vendor view
   assign vend_wr = apply_wr({1'b0, vend_ien_reg, 1'b0, go_reg, 4'h0}, i_reg_req.wdata, 8'h50,
                             i_reg_req.addr, ADDR_VEND_WR);

   // Enable register
   always_comb begin
      en_next = en_reg;
      if (i_reg_req.wr) begin
         en_next = apply_wr(en_reg, i_reg_req.wdata, EN_WMASK, i_reg_req.addr, ADDR_EN_WR);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_reg <= EN_RESET;
      end else begin
         en_reg <= en_next;
      end
   end

   // Vendor controls; start also leaves as the converter's run level
   always_comb begin
      vend_ien_next = vend_ien_reg;
      go_next = go_reg;
      if (i_reg_req.wr) begin
         vend_ien_next = vend_wr[VEND_IEN_BIT];
         go_next = vend_wr[VEND_GO_BIT];
      end
      // Completion outranks a start written in the same cycle
      if (conv_end) begin
         go_next = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vend_ien_reg <= 1'b0;
         go_reg <= 1'b0;
         o_resistor_conv_go <= 1'b0;
      end else begin
         vend_ien_reg <= vend_ien_next;
         go_reg <= go_next;
         o_resistor_conv_go <= go_next;
      end
   end

   // Converter timing: a start dropped mid-run aborts the measurement
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         CONV_IDLE: begin
            cnt_next = '0;
            if (go_reg) begin
               state_next = CONV_BUSY;
            end
         end
         CONV_BUSY: begin
            cnt_next = cnt_reg + CONV_CNT_W'(1);
            if (!go_reg || conv_end) begin
               state_next = CONV_IDLE;
            end
         end
         default: begin
            state_next = CONV_IDLE;
            cnt_next = '0;
         end
      endcase
   end

   // Result, done flag and latches; set beats clear-on-read
   always_comb begin
      code_next = code_reg;
      done_next = done_reg;
      latch_next = latch_reg;
      alt_next = 1'b0;
      id_prev_next = id_open_now;
      if (i_reg_req.rd && (i_reg_req.addr >= ADDR_VEND_WR) && (i_reg_req.addr <= ADDR_VEND_CLR)) begin
         done_next = 1'b0;
      end
      if (i_reg_req.rd && (i_reg_req.addr == ADDR_LATCH)) begin
         latch_next = LATCH_RESET;
      end
      if (conv_end) begin
         code_next = i_resistor_code_meas;
         done_next = 1'b1;
         if (!done_reg && conv_irq_en) begin
            latch_next[LATCH_CONV_BIT] = 1'b1;
            alt_next = 1'b1;
         end
      end
      // Edges come from the filtered level, whose reset value matches id_prev_reg
      if ((id_rise && en_reg[EN_RISE_BIT]) || (id_fall && en_reg[EN_FALL_BIT])) begin
         latch_next[LATCH_ID_BIT] = 1'b1;
         alt_next = 1'b1;
      end
   end

   // Read data one cycle after the request
   always_comb begin
      rvalid_next = i_reg_req.rd;
      rdata_next = 8'h00;
      if (i_reg_req.rd) begin
         case (i_reg_req.addr)
            ADDR_EN_WR, ADDR_EN_SET, ADDR_EN_CLR: rdata_next = en_reg;
            ADDR_STATUS: rdata_next = status_val;
            ADDR_LATCH: rdata_next = latch_reg;
            ADDR_VEND_WR, ADDR_VEND_SET, ADDR_VEND_CLR: rdata_next = vend_val;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // Converter state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= CONV_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Result, done flag, latches and the event pulse
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         id_prev_reg <= 1'b0;
         latch_reg <= LATCH_RESET;
         code_reg <= CODE_RESET;
         done_reg <= 1'b0;
         o_alt_int <= 1'b0;
      end else begin
         id_prev_reg <= id_prev_next;
         latch_reg <= latch_next;
         code_reg <= code_next;
         done_reg <= done_next;
         o_alt_int <= alt_next;
      end
   end

   // Read port
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rdata <= rdata_next;
         o_reg_rvalid <= rvalid_next;
      end
   end
endmodule
`default_nettype wire

//--- dv/idei_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module idei_conv_model (
   // Clock and converter control
   input wire logic i_clk,
   input wire logic i_go,
   // Result lines
   input wire logic [2:0] i_code,
   output logic [2:0] o_code
);
   // Outside a run the result is not valid, so show the inverse rather than a stale code
   always_ff @(posedge i_clk) o_code <= i_go ? i_code : ~i_code;
endmodule
`default_nettype wire

//--- dv/idei_checker.sv
`timescale 1ns/1ps
`default_nettype none
module idei_checker
   import idei_pkg::*;
#(
   parameter int CONV_CYCLES = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire idei_reg_req_t i_reg_req,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_id_open,
   input wire logic [2:0] i_resistor_code_meas,
   input wire logic o_resistor_conv_go,
   input wire logic o_alt_int
);
   int go_cnt_reg;
   int go_cnt_next;
   logic rd_en, rd_st, rd_la;
   assign rd_en = i_reg_req.rd && i_reg_req.addr inside {ADDR_EN_WR, ADDR_EN_SET, ADDR_EN_CLR};
   assign rd_st = i_reg_req.rd && i_reg_req.addr == ADDR_STATUS;
   assign rd_la = i_reg_req.rd && i_reg_req.addr == ADDR_LATCH;
   always_comb go_cnt_next = o_resistor_conv_go ? go_cnt_reg + 1 : 0;
   always_ff @(posedge i_clk or negedge i_rst_n) go_cnt_reg <= !i_rst_n ? 0 : go_cnt_next;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   rvalid_follows_a: assert property (o_reg_rvalid == $past(i_reg_req.rd))
      else $error("read valid misplaced");
   idle_zero_a: assert property (!o_reg_rvalid |-> o_reg_rdata == 8'h00)
      else $error("read data not zero when idle");
   en_unused_a: assert property (rd_en |=> (o_reg_rdata & 8'hdc) == 8'h00)
      else $error("enable unused bits set");
   status_unused_a: assert property (rd_st |=> (o_reg_rdata & 8'h86) == 8'h00)
      else $error("status unused bits set");
   latch_unused_a: assert property (rd_la |=> (o_reg_rdata & 8'hf6) == 8'h00)
      else $error("latch unused bits set");
   latch_clears_a: assert property (rd_la ##1 (rd_la && !o_alt_int) |=> o_reg_rdata == 8'h00)
      else $error("latch not cleared by read");
   latch_keeps_a: assert property (rd_la ##1 (rd_la && o_alt_int) |=> o_reg_rdata != 8'h00)
      else $error("latch event lost to read");
   id_live_a: assert property ($stable(i_id_open)[*6] ##0 rd_st |=> o_reg_rdata[0] == $past(i_id_open))
      else $error("status float bit wrong");
   conv_bounded_a: assert property (o_resistor_conv_go |-> go_cnt_reg <= CONV_CYCLES)
      else $error("conversion start held too long");
   unmapped_zero_a: assert property (i_reg_req.rd && i_reg_req.addr == 6'h00 |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind idei_top idei_checker #(.CONV_CYCLES(CONV_CYCLES)) idei_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_id_open(i_id_open),
   .i_resistor_code_meas(i_resistor_code_meas), .o_resistor_conv_go(o_resistor_conv_go), .o_alt_int(o_alt_int));
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import idei_pkg::*;
   localparam int CONV = 8;
   logic i_clk = 0, i_rst_n = 0, id_open = 0, rvalid, go, alt;
   idei_reg_req_t req = '0;
   logic [2:0] code_drv = 3'h0, code_meas;
   logic [7:0] rdata;
   int bad_count = 0, checks_done = 0, cyc = 0, alt_n = 0, alt_exp = 0, seed = 32'h490d;
   int en = 0, ven, e, v;
   always #5 i_clk = ~i_clk;
   idei_top #(.CONV_CYCLES(CONV)) idei_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_req(req),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_id_open(id_open), .i_resistor_code_meas(code_meas),
      .o_resistor_conv_go(go), .o_alt_int(alt));
   idei_conv_model idei_conv_model_inst (.i_clk(i_clk), .i_go(go), .i_code(code_drv), .o_code(code_meas));
   task automatic results();
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string name, input int exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp[7:0]) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp[7:0], got);
      end
   endtask
   task automatic acc(input logic r, input logic w, input logic [5:0] ad, input int d);
      req = '{rd: r, wr: w, addr: ad, wdata: d[7:0]};
      // Left standing until the next call or idle replaces it
      @(posedge i_clk);
      #1;
   endtask
   task automatic rd_chk(input logic [5:0] ad, input int exp);
      acc(1, 0, ad, 0);
      chk("read valid", 1, {7'h00, rvalid});
      chk("read data", exp, rdata);
   endtask
   task automatic idle(input int n);
      req = '0;
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (alt === 1'b1) alt_n++;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      #1 i_rst_n = 1;
      rd_chk(ADDR_EN_WR, 0);
      rd_chk(6'h00, 0);
      acc(0, 1, ADDR_STATUS, 8'hff);
      acc(0, 1, ADDR_LATCH, 8'hff);
      rd_chk(ADDR_STATUS, 0);
      rd_chk(ADDR_LATCH, 0);
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         acc(0, 1, 6'(ADDR_EN_WR + i % 3), v);
         en = (i % 3 == 0) ? (v & 8'h23) : (i % 3 == 1) ? (en | (v & 8'h23)) : (en & ~v & 8'h23);
         rd_chk(6'(ADDR_EN_WR + (i + 1) % 3), en);
      end
      for (int i = 0; i < 4; i++) begin
         acc(0, 1, ADDR_EN_WR, i);
         for (int p = 0; p < 2; p++) begin
            id_open = !id_open;
            idle(8);
            e = id_open ? (i & 1) : (i >> 1);
            alt_exp += e;
            rd_chk(ADDR_STATUS, id_open);
            rd_chk(ADDR_LATCH, e);
            rd_chk(ADDR_LATCH, 0);
         end
      end
      // An ID edge landing on a latch read must survive that read
      acc(0, 1, ADDR_EN_WR, 3);
      id_open = 1;
      idle(4);
      rd_chk(ADDR_LATCH, 0);
      rd_chk(ADDR_LATCH, 1);
      rd_chk(ADDR_LATCH, 0);
      id_open = 0;
      idle(8);
      rd_chk(ADDR_LATCH, 1);
      alt_exp += 2;
      // Every code, with the interrupt enabled from either register or neither
      for (int k = 0; k < 8; k++) begin
         acc(0, 1, ADDR_EN_WR, (k & 1) << 5);
         ven = (k >> 1) & 1;
         code_drv = 3'(k);
         acc(0, 1, ADDR_VEND_WR, 8'h10 | ven << 6);
         chk("conversion start", 1, {7'h00, go});
         idle(CONV + 3);
         chk("conversion start", 0, {7'h00, go});
         e = (k & 1) | ven;
         alt_exp += e;
         rd_chk(ADDR_STATUS, 8'h40 | k << 3);
         rd_chk(ADDR_STATUS, 8'h40 | k << 3);
         rd_chk(ADDR_LATCH, e << 3);
         rd_chk(ADDR_VEND_WR, ven << 6 | 8 | k);
         rd_chk(ADDR_STATUS, k << 3);
      end
      chk("alt pulses", alt_exp, alt_n[7:0]);
      results();
   end
endmodule
`default_nettype wire
